// *** logic/otpd_top.sv ***
// Output terminal polarity and on/off delay block with an APB register slave.
// Notes on behaviour
// - Open-collector polarity setting 00 is normally open, 01 normally closed.
// - Relay has its own polarity setting, 00 normally open, 01 normally closed.
// - Normally open: contact closed while the signal is asserted, open otherwise.
// - Normally closed: contact open while the signal is asserted, closed otherwise.
// - Relay pairs are complementary; unpowered or reset, first open, second closed.
// - With zero delay an output follows its signal at once.
// - Each output holds on-delay and off-delay, 0.0 to 100.0 seconds.
// - Exactly two delayed outputs, four delay settings in total.
// - On-delay postpones assertion, off-delay extends it.
// - Each output's signal is the drive function chosen by its selector.
//
// Implementation choices: the APB slave port and the placing of the registers.
`timescale 1ns/1ps
`include "otpd_consts.svh"
module otpd_top
	import otpd_pkg::*;
#(
	parameter int unsigned TICK_CYCLES = `OTPD_STEP_NS / `OTPD_CLK_NS // Cycles per 0.1 s.
)(
	input  wire logic                        core_clk,    // 10 MHz clock.
	input  wire logic                        rst_n,       // Asynchronous reset, active low.
	input  wire logic                        psel,        // APB select.
	input  wire logic                        penable,     // APB enable.
	input  wire logic                        pwrite,      // APB direction, high for write.
	input  wire logic [7:0]                  paddr,       // APB byte address.
	input  wire logic [31:0]                 pwdata,      // APB write data.
	output logic      [31:0]                 prdata,      // APB read data.
	output logic                             pready,      // APB ready.
	output logic                             pslverr,     // APB error on unmapped address.
	input  wire logic [`OTPD_FUNC_COUNT-1:0] driveFuncs,  // Drive status, bit n is function n.
	output logic                             collectorOut, // High while the contact is closed.
	output logic                             relayFirstPair, // High while first pair is closed.
	output logic                             relaySecondPair // High while second pair is closed.
);
	localparam int unsigned TW = $clog2(TICK_CYCLES + 1);

	// Picks the selected function; a selector beyond the list means no assignment.
	function automatic logic pickFunc(input logic [`OTPD_FUNC_W-1:0] sel,
		input logic [`OTPD_FUNC_COUNT-1:0] funcs);
		logic hit;
		hit = 1'b0;
		if (sel < `OTPD_FUNC_COUNT)
			hit = funcs[sel[5:0]];
		return hit;
	endfunction

	// Clamps a written delay to the longest legal value.
	function automatic logic [`OTPD_DELAY_W-1:0] clampDelay(input logic [31:0] v);
		logic [`OTPD_DELAY_W-1:0] r;
		r = `OTPD_DELAY_MAX;
		if (v <= 32'(`OTPD_DELAY_MAX))
			r = v[`OTPD_DELAY_W-1:0];
		return r;
	endfunction

	otpd_ctrl_t               ctrlQ;
	logic [`OTPD_DELAY_W-1:0] onDlyQ  [2];
	logic [`OTPD_DELAY_W-1:0] offDlyQ [2];
	logic [TW-1:0]            divQ;
	logic                     tickQ;
	logic [1:0]               rawSig;
	logic [1:0]               delayed;
	logic                     collQ, firstQ, secondQ;
	logic [31:0]              rdataQ;
	logic                     readyQ, errQ;
	otpd_status_t             status;

	// Bus decode: setup phase selects the answer, access phase commits writes.
	wire setup    = psel && !penable;
	wire doWrite  = psel && penable && pready && pwrite;
	wire otpd_ctrl_t wrCtrl = otpd_ctrl_t'(pwdata); // Write data seen as control fields.
	wire selCtrl  = paddr == `OTPD_ADDR_CTRL;
	wire selCOn   = paddr == `OTPD_ADDR_COLL_ON;
	wire selCOff  = paddr == `OTPD_ADDR_COLL_OFF;
	wire selROn   = paddr == `OTPD_ADDR_RELAY_ON;
	wire selROff  = paddr == `OTPD_ADDR_RELAY_OFF;
	wire selStat  = paddr == `OTPD_ADDR_STATUS;
	wire mapped   = selCtrl | selCOn | selCOff | selROn | selROff | selStat;
	wire [1:0] selOn  = {selROn, selCOn};
	wire [1:0] selOff = {selROff, selCOff};
	wire [31:0] rdMux = selCtrl ? 32'(ctrlQ) :
		selCOn  ? 32'(onDlyQ[0])  : selCOff ? 32'(offDlyQ[0]) :
		selROn  ? 32'(onDlyQ[1])  : selROff ? 32'(offDlyQ[1]) :
		selStat ? 32'(status) : 32'h0000_0000;

	assign rawSig[0] = pickFunc(ctrlQ.collFunc, driveFuncs);
	assign rawSig[1] = pickFunc(ctrlQ.relayFunc, driveFuncs);

	// Contact state before the output flops; polarity bit 0 inverts.
	wire collNext  = delayed[0] ^ ctrlQ.collPol[0];
	wire firstNext = delayed[1] ^ ctrlQ.relayPol[0];

	assign status = '{spare: '0, relayFirstClosed: firstQ, collClosed: collQ,
		relayDelayed: delayed[1], relayRaw: rawSig[1],
		collDelayed: delayed[0], collRaw: rawSig[0]};
	assign prdata          = rdataQ;
	assign pready          = readyQ;
	assign pslverr         = errQ;
	assign collectorOut    = collQ;
	assign relayFirstPair  = firstQ;
	assign relaySecondPair = secondQ;

	// APB answer: ready in the cycle after setup, so every transfer has no wait state.
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			readyQ <= 1'b0;
			errQ   <= 1'b0;
			rdataQ <= 32'h0000_0000;
		end else begin
			readyQ <= setup;
			errQ   <= setup && !mapped;
			rdataQ <= (setup && !pwrite) ? rdMux : 32'h0000_0000;
		end
	end

	// control register fields; the relay defaults to normally closed.
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			ctrlQ <= '{spare: '0, relayFunc: `OTPD_RST_RELAY_FUNC,
				collFunc: `OTPD_RST_COLL_FUNC, spare2: '0,
				relayPol: otpd_pol_t'(`OTPD_RST_RELAY_POL),
				collPol: otpd_pol_t'(`OTPD_RST_COLL_POL)};
		end else if (doWrite && selCtrl) begin
			ctrlQ.relayFunc <= wrCtrl.relayFunc;
			ctrlQ.collFunc  <= wrCtrl.collFunc;
			ctrlQ.relayPol  <= otpd_pol_t'({1'b0, wrCtrl.relayPol[0]});
			ctrlQ.collPol   <= otpd_pol_t'({1'b0, wrCtrl.collPol[0]});
		end
	end

	// The step divider is shared, so the first step of a delay may be short by up to 0.1 s.
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			divQ  <= '0;
			tickQ <= 1'b0;
		end else begin
			divQ  <= (divQ == TW'(TICK_CYCLES - 1)) ? '0 : divQ + 1'b1;
			tickQ <= divQ == TW'(TICK_CYCLES - 1);
		end
	end

	for (genvar i = 0; i < 2; i++) begin : gOut
		always_ff @(posedge core_clk or negedge rst_n) begin
			if (!rst_n) begin
				onDlyQ[i]  <= `OTPD_RST_DELAY;
				offDlyQ[i] <= `OTPD_RST_DELAY;
			end else if (doWrite) begin
				if (selOn[i])
					onDlyQ[i] <= clampDelay(pwdata);
				if (selOff[i])
					offDlyQ[i] <= clampDelay(pwdata);
			end
		end

		otpd_delay uDelay (
			.core_clk   (core_clk),
			.rst_n      (rst_n),
			.stepTick   (tickQ),
			.rawIn      (rawSig[i]),
			.onDelay    (onDlyQ[i]),
			.offDelay   (offDlyQ[i]),
			.delayedOut (delayed[i])
		);
	end

	// relay pairs complementary, first open in reset.
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			collQ   <= 1'b0;
			firstQ  <= 1'b0;
			secondQ <= 1'b1;
		end else begin
			collQ   <= collNext;
			firstQ  <= firstNext;
			secondQ <= !firstNext;
		end
	end

	a_coll_polarity: assert property (@(posedge core_clk) disable iff (!rst_n)
		collectorOut == ($past(delayed[0]) ^ $past(ctrlQ.collPol[0])) || $rose(rst_n))
		else $error("Collector contact disagrees with signal and polarity.");
	a_relay_nc_mode: assert property (@(posedge core_clk) disable iff (!rst_n)
		ctrlQ.relayPol == OTPD_POL_NC && delayed[1] ##1 ctrlQ.relayPol == OTPD_POL_NC
		|-> !relayFirstPair)
		else $error("Normally closed relay first pair closed while asserted.");
	a_relay_pairs: assert property (@(posedge core_clk) disable iff (!rst_n)
		relayFirstPair != relaySecondPair)
		else $error("Relay contact pairs are not complementary.");
	a_func_select: assert property (@(posedge core_clk) disable iff (!rst_n)
		ctrlQ.collFunc < `OTPD_FUNC_COUNT |-> rawSig[0] == driveFuncs[ctrlQ.collFunc[5:0]])
		else $error("Collector follows the wrong function.");
	a_step_spacing: assert property (@(posedge core_clk) disable iff (!rst_n)
		tickQ && TICK_CYCLES > 1 |=> !tickQ)
		else $error("Step ticks came back to back.");
	a_apb_answer: assert property (@(posedge core_clk) disable iff (!rst_n)
		psel && !penable |=> pready ##1 !pready || (psel && !penable))
		else $error("APB answer not given in the access cycle.");
	c_coll_closes: cover property (@(posedge core_clk) disable iff (!rst_n) $rose(collectorOut));
	c_relay_trips: cover property (@(posedge core_clk) disable iff (!rst_n) $rose(relayFirstPair));
	c_bus_error: cover property (@(posedge core_clk) disable iff (!rst_n) pready && pslverr);
endmodule // otpd_top

// *** logic/otpd_consts.svh ***
// Constants for the output terminal polarity and delay block.
`ifndef OTPD_CONSTS_SVH
`define OTPD_CONSTS_SVH

// Register byte offsets.
`define OTPD_ADDR_CTRL      8'h00
`define OTPD_ADDR_COLL_ON   8'h04
`define OTPD_ADDR_COLL_OFF  8'h08
`define OTPD_ADDR_RELAY_ON  8'h0C
`define OTPD_ADDR_RELAY_OFF 8'h10
`define OTPD_ADDR_STATUS    8'h14

// Reset values of the control fields and of the delay registers.
`define OTPD_RST_COLL_POL   2'h0
`define OTPD_RST_RELAY_POL  2'h1
`define OTPD_RST_COLL_FUNC  8'h00
`define OTPD_RST_RELAY_FUNC 8'h05
`define OTPD_RST_DELAY      10'h000

// Delay range in 0.1 s steps: 0.0 to 100.0 s.
`define OTPD_DELAY_MAX      10'h3E8
`define OTPD_DELAY_W        10

// Number of selectable drive functions and the width of a selector.
`define OTPD_FUNC_COUNT     64
`define OTPD_FUNC_W         8

// Time base: one delay step is 0.1 s, the clock period is 100 ns.
`define OTPD_STEP_NS        100000000
`define OTPD_CLK_NS         100

`endif

// *** logic/otpd_pkg.sv ***
// Types for the output terminal polarity and delay block.
package otpd_pkg;

	// Contact polarity setting: normally open or normally closed.
	typedef enum logic [1:0] {
		OTPD_POL_NO = 2'h0,
		OTPD_POL_NC = 2'h1
	} otpd_pol_t;

	// Control register layout, most significant field first.
	typedef struct packed {
		logic [7:0] spare;
		logic [7:0] relayFunc;
		logic [7:0] collFunc;
		logic [3:0] spare2;
		otpd_pol_t  relayPol;
		otpd_pol_t  collPol;
	} otpd_ctrl_t;

	// Status register layout.
	typedef struct packed {
		logic [25:0] spare;
		logic        relayFirstClosed;
		logic        collClosed;
		logic        relayDelayed;
		logic        relayRaw;
		logic        collDelayed;
		logic        collRaw;
	} otpd_status_t;

endpackage

// *** logic/otpd_delay.sv ***
// On-delay and off-delay filter for one output terminal.
`timescale 1ns/1ps
`include "otpd_consts.svh"
module otpd_delay
	import otpd_pkg::*;
(
	input  wire logic                     core_clk,  // System clock.
	input  wire logic                     rst_n,     // Asynchronous reset, active low.
	input  wire logic                     stepTick,  // One pulse per 0.1 s step.
	input  wire logic                     rawIn,     // Selected internal signal.
	input  wire logic [`OTPD_DELAY_W-1:0] onDelay,   // On-delay in steps.
	input  wire logic [`OTPD_DELAY_W-1:0] offDelay,  // Off-delay in steps.
	output logic                          delayedOut // Filtered signal.
);
	logic                     stateQ;
	logic [`OTPD_DELAY_W-1:0] cntQ;
	wire                      pending = rawIn != stateQ;
	wire [`OTPD_DELAY_W-1:0]  limit   = rawIn ? onDelay : offDelay;
	wire                      expired = cntQ >= limit;

	assign delayedOut = stateQ;

	// whole steps, short glitches dropped.
	// A change that reverts before its delay expires resets the count, so it never shows.
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			stateQ <= 1'b0;
			cntQ   <= `OTPD_RST_DELAY;
		end else if (!pending) begin
			cntQ <= `OTPD_RST_DELAY;
		end else if (expired) begin
			stateQ <= rawIn;
			cntQ   <= `OTPD_RST_DELAY;
		end else if (stepTick) begin
			cntQ <= cntQ + 1'b1;
		end
	end

	a_zero_on_follows: assert property (@(posedge core_clk) disable iff (!rst_n)
		rawIn && !stateQ && onDelay == `OTPD_RST_DELAY |=> stateQ)
		else $error("Output did not follow at once with zero on-delay.");
	a_rise_needs_cause: assert property (@(posedge core_clk) disable iff (!rst_n)
		$rose(stateQ) |-> $past(rawIn) && $past(cntQ) >= $past(onDelay))
		else $error("Output rose before its on-delay expired.");
	a_fall_needs_cause: assert property (@(posedge core_clk) disable iff (!rst_n)
		$fell(stateQ) |-> !$past(rawIn) && $past(cntQ) >= $past(offDelay))
		else $error("Output fell before its off-delay expired.");
	a_count_in_range: assert property (@(posedge core_clk) disable iff (!rst_n)
		onDelay <= `OTPD_DELAY_MAX && offDelay <= `OTPD_DELAY_MAX |-> cntQ <= `OTPD_DELAY_MAX)
		else $error("Delay count ran past the longest delay.");
	c_delayed_rise: cover property (@(posedge core_clk) disable iff (!rst_n)
		$rose(stateQ) && $past(onDelay) != `OTPD_RST_DELAY);
endmodule // otpd_delay

// *** bench/otpd_ext_equip.sv ***
// Model of the wiring outside the block: a controller input and two lamps.
`timescale 1ns/1ps
module otpd_ext_equip (
	input  wire logic collectorOut,    // Transistor conducting.
	input  wire logic relayFirstPair,  // First pair closed.
	input  wire logic relaySecondPair, // Second pair closed.
	output logic      plcInputHigh,    // Controller input with pull-up.
	output logic      alarmLampOn,     // Lamp through the first pair.
	output logic      runLampOn        // Lamp through the second pair.
);
	// A conducting transistor sinks the pull-up; anything else lets it rise.
	assign plcInputHigh = (collectorOut === 1'b1) ? 1'b0 : 1'b1;
	// A lamp lights only through a pair that is really closed.
	assign alarmLampOn = (relayFirstPair === 1'b1);
	assign runLampOn = (relaySecondPair === 1'b1);
endmodule // otpd_ext_equip

// *** bench/tb_top.sv ***
// Self-checking bench for the output terminal polarity and delay block.
`timescale 1ns/1ps
module tb_top
	import otpd_pkg::*;
;
	localparam int unsigned TICKS = 10; // Short step keeps delay runs brief.
	logic        core_clk, rst_n, psel, penable, pwrite, err;
	logic        pready, pslverr, collectorOut, relayFirstPair, relaySecondPair;
	logic        plcInputHigh, alarmLampOn, runLampOn;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [63:0] driveFuncs;
	int          num_errors, total_checks;
	otpd_ctrl_t  ctrl;

	otpd_top #(.TICK_CYCLES(TICKS)) dut (.core_clk(core_clk), .rst_n(rst_n), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .driveFuncs(driveFuncs),
		.collectorOut(collectorOut), .relayFirstPair(relayFirstPair),
		.relaySecondPair(relaySecondPair));
	otpd_ext_equip equip (.collectorOut(collectorOut), .relayFirstPair(relayFirstPair),
		.relaySecondPair(relaySecondPair), .plcInputHigh(plcInputHigh),
		.alarmLampOn(alarmLampOn), .runLampOn(runLampOn));

	// Free-running 10 MHz clock.
	always #50 core_clk = ~core_clk;

	// Counts a comparison and reports a difference at once.
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		total_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask

	// Prints the verdict and ends the run.
	task automatic results();
		if (num_errors == 0 && total_checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	// One APB transfer; the request stands until pready is sampled high at a rising edge.
	// Read data and the error flag are taken at that same edge, then the request is released.
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge core_clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge core_clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge core_clk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (pready !== 1'b1) begin
			chk("pready", 32'h1, 32'h0);
			results();
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	// The collector level must hold for n cycles.
	task automatic holdColl(input int n, input logic lvl);
		repeat (n) begin
			@(negedge core_clk);
			chk("collectorOut", {31'h0, lvl}, {31'h0, collectorOut});
		end
	endtask

	// Bounded wait for the collector to reach a level; a miss ends the run.
	// The first look is on a falling edge, so a value launched at this rising edge is never seen early.
	task automatic waitColl(input int limit, input logic lvl);
		@(negedge core_clk);
		for (int n = 0; n < limit && collectorOut !== lvl; n++) @(negedge core_clk);
		chk("collectorOut", {31'h0, lvl}, {31'h0, collectorOut});
		if (collectorOut !== lvl) results();
	endtask

	// Unpowered relay state, then reset values after release.
	task automatic resetCheck();
		repeat (16) @(posedge core_clk);
		chk("relayFirstPair", 32'h0, {31'h0, relayFirstPair});
		chk("relaySecondPair", 32'h1, {31'h0, relaySecondPair});
		rst_n <= 1'b1;
		apb(1'b0, 8'h00, 32'h0);
		chk("ctrl", 32'h0005_0004, rd);
		apb(1'b0, 8'h14, 32'h0);
		chk("status", 32'h0000_0020, rd);
		chk("relayFirstPair", 32'h1, {31'h0, relayFirstPair});
		chk("runLampOn", 32'h0, {31'h0, runLampOn});
	endtask

	// Both polarities against both signal levels, other functions inverted.
	task automatic polarityTable();
		logic c;
		for (int i = 0; i < 4; i++) begin
			ctrl = '0;
			ctrl.collPol = i[1] ? OTPD_POL_NC : OTPD_POL_NO;
			ctrl.relayPol = ctrl.collPol;
			ctrl.collFunc = 8'h02;
			ctrl.relayFunc = 8'h21;
			apb(1'b1, 8'h00, ctrl);
			driveFuncs <= {64{~i[0]}} ^ 64'h0000_0002_0000_0004;
			repeat (2) @(posedge core_clk);
			@(negedge core_clk);
			c = i[0] ^ i[1];
			chk("collectorOut", {31'h0, c}, {31'h0, collectorOut});
			chk("plcInputHigh", {31'h0, ~c}, {31'h0, plcInputHigh});
			chk("relayFirstPair", {31'h0, c}, {31'h0, relayFirstPair});
			chk("alarmLampOn", {31'h0, c}, {31'h0, alarmLampOn});
			chk("relaySecondPair", {31'h0, ~c}, {31'h0, relaySecondPair});
		end
	endtask

	// Delay registers, clamp, and the unmapped address.
	task automatic registerAccess();
		for (int a = 4; a <= 16; a += 4) apb(1'b1, 8'(a), 32'(a * 3));
		for (int a = 4; a <= 16; a += 4) begin
			apb(1'b0, 8'(a), 32'h0);
			chk("delay", 32'(a * 3), rd);
		end
		apb(1'b1, 8'h04, 32'h0000_07FF);
		apb(1'b0, 8'h04, 32'h0);
		chk("clamp", 32'h0000_03E8, rd);
		apb(1'b0, 8'h18, 32'h0);
		chk("pslverr", 32'h1, {31'h0, err});
	endtask

	// Short pulses and gaps are swallowed, held levels pass late.
	// The earlier scenarios leave the collector filter asserted, so it is first let down to rest.
	task automatic delayFilter();
		driveFuncs <= 64'h0;
		apb(1'b1, 8'h00, 32'h0001_0200);
		apb(1'b1, 8'h08, 32'h0000_0002);
		apb(1'b1, 8'h04, 32'h0000_0003);
		waitColl(40, 1'b0);
		@(posedge core_clk);
		driveFuncs <= 64'h0000_0000_0000_0004;
		repeat (5) @(posedge core_clk);
		driveFuncs <= 64'h0;
		holdColl(40, 1'b0);
		@(posedge core_clk);
		driveFuncs <= 64'h0000_0000_0000_0004;
		holdColl(19, 1'b0);
		waitColl(16, 1'b1);
		@(posedge core_clk);
		driveFuncs <= 64'h0;
		repeat (3) @(posedge core_clk);
		driveFuncs <= 64'h0000_0000_0000_0004;
		holdColl(40, 1'b1);
		@(posedge core_clk);
		driveFuncs <= 64'h0;
		holdColl(9, 1'b1);
		waitColl(16, 1'b0);
	endtask

	// Main sequence.
	initial begin
		core_clk = 1'b0;
		rst_n = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		driveFuncs = 64'h0;
		num_errors = 0;
		total_checks = 0;
		resetCheck();
		polarityTable();
		registerAccess();
		delayFilter();
		results();
	end
endmodule // tb_top
